// ### rtl/chunk_fifo.sv
`timescale 1ns/1ps
module chunk_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stall request from the consumer logic
    input wire logic hold_next,
    // fill side
    input wire logic s_valid,
    input wire logic [WIDTH-1:0] s_data,
    output logic s_ready,
    // drain side
    output logic m_valid,
    output logic [WIDTH-1:0] m_data,
    input wire logic m_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [CW-1:0] count_reg, count_next;
    logic ready_reg, ready_next;
    logic push, pop;

    assign push = s_valid & ready_reg;
    assign pop = m_valid & m_ready;
    assign m_valid = (count_reg != '0);
    assign m_data = mem_reg[rd_reg];
    assign s_ready = ready_reg;

    always_comb begin
        wr_next = wr_reg;
        rd_next = rd_reg;
        count_next = count_reg;
        if (push) begin
            wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
        end
        if (push && !pop) begin
            count_next = count_reg + CW'(1);
        end else if (pop && !push) begin
            count_next = count_reg - CW'(1);
        end
        // registered ready: decided one cycle ahead from next count
        ready_next = (count_next != CW'(DEPTH)) && !hold_next;
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= s_data;
        end
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            count_reg <= count_next;
            ready_reg <= ready_next;
        end
    end

endmodule : chunk_fifo

// ### rtl/resync_dc_balance_selector.sv
`timescale 1ns/1ps
// Notes on behaviour
// - core is seven zeros, one, six zeros
// - each resync area is two bytes
// - fixed part then tail 000y or 100y
// - tails differ in count of ones
// - pattern detectable from either edge alone
// - toggle waveform level on every one bit
// - zero level counts -1, one counts +1
// - head, block 0, then fixed, tail, block
// - conversion starts from last real level
// - seed sum, pick tail with smaller magnitude
// - final step omits trailing fixed part
// - one selection per step, 1 to 39
// - tie picks first tail variant
// - encoder supplies tail's last bit
// - encoder closes block assuming zero bits
// - one bit inverted to break code
module resync_dc_balance_selector #(
    parameter int N_STEPS = resync_pkg::N_STEPS,
    parameter int DEPTH = resync_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // chunks from the modulation encoder
    input wire logic in_valid,
    input wire resync_pkg::chunk_s in_chunk,
    output logic in_ready,
    // channel bits to the serialiser
    output logic out_valid,
    output resync_pkg::chan_out_s out_data,
    input wire logic out_ready,
    // selection state
    output logic tail_variant_b,
    output logic signed [resync_pkg::SUM_W-1:0] running_sum
);
    localparam int CW = resync_pkg::CHUNK_W;
    localparam int NW = resync_pkg::NBITS_W;
    localparam int SW = resync_pkg::SUM_W;
    localparam int TW = resync_pkg::STEP_W;

    typedef enum {DECIDE, TAIL, DATA, FIX} read_state_e;

    // ==========================================
    // fifo
    logic push, pop, fifo_valid, pend_valid_next;
    resync_pkg::chunk_s fifo_chunk;

    assign push = in_valid & in_ready;

    chunk_fifo #(
        .WIDTH($bits(resync_pkg::chunk_s)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .hold_next(pend_valid_next),
        .s_valid(in_valid),
        .s_data(in_chunk),
        .s_ready(in_ready),
        .m_valid(fifo_valid),
        .m_data(fifo_chunk),
        .m_ready(pop)
    );

    // ==========================================
    // fill side: block balance from a level-0 start
    // one block result is held; input stalls while it waits
    logic signed [SW-1:0] ws_sum_reg, ws_sum_next;
    logic ws_lvl_reg, ws_lvl_next, ws_first_reg, ws_first_next;
    logic ws_y_reg, ws_y_next, ws_head_reg, ws_head_next;
    logic signed [SW-1:0] pend_sum_reg, pend_sum_next;
    logic pend_valid_reg, pend_y_reg, pend_y_next, pend_x_reg, pend_x_next;
    logic pend_final_reg, pend_final_next, pend_head_reg, pend_head_next;
    logic take_pend;
    resync_pkg::dsv_s wd, fd;

    always_comb begin
        ws_sum_next = ws_sum_reg;
        ws_lvl_next = ws_lvl_reg;
        ws_first_next = ws_first_reg;
        ws_y_next = ws_y_reg;
        ws_head_next = ws_head_reg;
        pend_valid_next = pend_valid_reg & ~take_pend;
        pend_sum_next = pend_sum_reg;
        pend_y_next = pend_y_reg;
        pend_x_next = pend_x_reg;
        pend_final_next = pend_final_reg;
        pend_head_next = pend_head_reg;
        wd = resync_pkg::pwm_dsv(in_chunk.data, in_chunk.nbits,
                                 ws_lvl_reg);
        fd = resync_pkg::pwm_dsv(resync_pkg::fix_vector(in_chunk.x_bit),
                                 NW'(resync_pkg::FIX_W), wd.lvl);
        if (push) begin
            if (ws_first_reg) begin
                ws_y_next = in_chunk.y_bit;
            end
            if (in_chunk.last_of_block) begin
                pend_valid_next = 1'b1;
                // final block: no fixed part after it
                pend_sum_next = in_chunk.last_of_field ?
                    ws_sum_reg + wd.sum :
                    ws_sum_reg + wd.sum + fd.sum;
                pend_y_next = ws_first_reg ? in_chunk.y_bit : ws_y_reg;
                pend_x_next = in_chunk.x_bit;
                pend_final_next = in_chunk.last_of_field;
                pend_head_next = ws_head_reg;
                ws_sum_next = '0;
                ws_lvl_next = 1'b0;
                ws_first_next = 1'b1;
                ws_head_next = in_chunk.last_of_field;
            end else begin
                ws_sum_next = ws_sum_reg + wd.sum;
                ws_lvl_next = wd.lvl;
                ws_first_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ws_sum_reg <= '0;
            ws_lvl_reg <= 1'b0;
            ws_first_reg <= 1'b1;
            ws_y_reg <= 1'b0;
            ws_head_reg <= 1'b1;
            pend_valid_reg <= 1'b0;
            pend_sum_reg <= '0;
            pend_y_reg <= 1'b0;
            pend_x_reg <= 1'b0;
            pend_final_reg <= 1'b0;
            pend_head_reg <= 1'b0;
        end else begin
            ws_sum_reg <= ws_sum_next;
            ws_lvl_reg <= ws_lvl_next;
            ws_first_reg <= ws_first_next;
            ws_y_reg <= ws_y_next;
            ws_head_reg <= ws_head_next;
            pend_valid_reg <= pend_valid_next;
            pend_sum_reg <= pend_sum_next;
            pend_y_reg <= pend_y_next;
            pend_x_reg <= pend_x_next;
            pend_final_reg <= pend_final_next;
            pend_head_reg <= pend_head_next;
        end
    end

    // ==========================================
    // drain side: tail choice and serial emission
    read_state_e state_reg, state_next;
    logic [CW-1:0] shift_reg, shift_next;
    logic [NW-1:0] cnt_reg, cnt_next, last_reg, last_next;
    logic have_reg, have_next, blk_end_reg, blk_end_next;
    logic final_reg, final_next, x_reg, x_next, lvl_reg, lvl_next;
    logic sel_b_reg, sel_b_next, ov_reg, ov_next;
    logic signed [SW-1:0] p_reg, p_next, cand_a, cand_b, abs_a, abs_b;
    logic [TW-1:0] step_reg, step_next;
    resync_pkg::chan_out_s od_reg, od_next;
    resync_pkg::dsv_s ta, tb;
    logic adv, emit, deciding;

    assign adv = ~ov_reg | out_ready;
    assign deciding = (state_reg == DECIDE) & pend_valid_reg;
    assign take_pend = deciding;
    assign pop = (state_reg == DATA) & ~have_reg & fifo_valid;

    always_comb begin
        // level carried over from the emitted stream
        ta = resync_pkg::pwm_dsv(resync_pkg::tail_vector(1'b0, pend_y_reg),
                                 NW'(resync_pkg::TAIL_W), lvl_reg);
        tb = resync_pkg::pwm_dsv(resync_pkg::tail_vector(1'b1, pend_y_reg),
                                 NW'(resync_pkg::TAIL_W), lvl_reg);
        // block sum from level 0 flips sign if it starts high
        cand_a = p_reg + ta.sum + (ta.lvl ? -pend_sum_reg : pend_sum_reg);
        cand_b = p_reg + tb.sum + (tb.lvl ? -pend_sum_reg : pend_sum_reg);
        abs_a = resync_pkg::abs_sum(cand_a);
        abs_b = resync_pkg::abs_sum(cand_b);
    end

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        last_next = last_reg;
        have_next = have_reg;
        blk_end_next = blk_end_reg;
        final_next = final_reg;
        x_next = x_reg;
        lvl_next = lvl_reg;
        sel_b_next = sel_b_reg;
        p_next = p_reg;
        step_next = step_reg;
        emit = 1'b0;
        ov_next = ov_reg & ~out_ready;
        od_next = od_reg;
        case (state_reg)
            DECIDE: begin
                if (pend_valid_reg) begin
                    x_next = pend_x_reg;
                    final_next = pend_final_reg;
                    if (pend_head_reg) begin
                        p_next = pend_sum_reg;
                        step_next = '0;
                        state_next = DATA;
                    end else begin
                        // strict less-than keeps variant a on a tie
                        sel_b_next = (abs_b < abs_a);
                        p_next = (abs_b < abs_a) ? cand_b : cand_a;
                        step_next = step_reg + TW'(1);
                        shift_next = resync_pkg::tail_vector(abs_b < abs_a,
                                                             pend_y_reg);
                        cnt_next = '0;
                        last_next = resync_pkg::TAIL_LAST;
                        state_next = TAIL;
                    end
                end
            end
            DATA: begin
                if (!have_reg) begin
                    if (fifo_valid) begin
                        shift_next = fifo_chunk.data;
                        last_next = fifo_chunk.nbits - NW'(1);
                        blk_end_next = fifo_chunk.last_of_block;
                        have_next = 1'b1;
                        cnt_next = '0;
                    end
                end else begin
                    emit = adv;
                end
            end
            default: begin
                emit = adv;
            end
        endcase
        if (emit) begin
            ov_next = 1'b1;
            od_next.ch = shift_reg[CW-1];
            od_next.resync = (state_reg != DATA);
            lvl_next = lvl_reg ^ shift_reg[CW-1];
            shift_next = shift_reg << 1;
            cnt_next = cnt_reg + NW'(1);
            if (cnt_reg == last_reg) begin
                cnt_next = '0;
                if (state_reg == TAIL) begin
                    state_next = DATA;
                end else if (state_reg == FIX) begin
                    state_next = DECIDE;
                end else begin
                    have_next = 1'b0;
                    if (blk_end_reg) begin
                        if (final_reg) begin
                            state_next = DECIDE;
                            lvl_next = 1'b0;
                        end else begin
                            // fixed part carries the irregular run
                            shift_next = resync_pkg::fix_vector(x_reg);
                            last_next = resync_pkg::FIX_LAST;
                            state_next = FIX;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= DECIDE;
            shift_reg <= '0;
            cnt_reg <= '0;
            last_reg <= '0;
            have_reg <= 1'b0;
            blk_end_reg <= 1'b0;
            final_reg <= 1'b0;
            x_reg <= 1'b0;
            lvl_reg <= 1'b0;
            sel_b_reg <= 1'b0;
            p_reg <= '0;
            step_reg <= '0;
            ov_reg <= 1'b0;
            od_reg <= '0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            last_reg <= last_next;
            have_reg <= have_next;
            blk_end_reg <= blk_end_next;
            final_reg <= final_next;
            x_reg <= x_next;
            lvl_reg <= lvl_next;
            sel_b_reg <= sel_b_next;
            p_reg <= p_next;
            step_reg <= step_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
        end
    end

    assign out_valid = ov_reg;
    assign out_data = od_reg;
    assign tail_variant_b = sel_b_reg;
    assign running_sum = p_reg;

    // ==========================================
    // checks
    AST_STEP_RANGE: assert property (@(posedge clk) disable iff (reset)
        step_reg <= TW'(N_STEPS))
        else $error("step index beyond last step");
    AST_TIE_A: assert property (@(posedge clk) disable iff (reset)
        (deciding && !pend_head_reg && abs_a == abs_b) |=> !sel_b_reg)
        else $error("tie did not choose variant a");
    AST_PICK_MIN: assert property (@(posedge clk) disable iff (reset)
        (deciding && !pend_head_reg) |=> (resync_pkg::abs_sum(p_reg) ==
        (($past(abs_b) < $past(abs_a)) ? $past(abs_b) : $past(abs_a))))
        else $error("running sum not the smaller candidate");
    AST_SEED: assert property (@(posedge clk) disable iff (reset)
        (deciding && pend_head_reg) |=> p_reg == $past(pend_sum_reg))
        else $error("sum not seeded from head segment");
    AST_TAIL_LEN: assert property (@(posedge clk) disable iff (reset)
        (state_reg == DECIDE && state_next == TAIL) |=>
        (state_reg == TAIL)[*4])
        else $error("tail shorter than four bits");
    AST_FIX_END: assert property (@(posedge clk) disable iff (reset)
        (state_reg == FIX && emit && cnt_reg == resync_pkg::FIX_LAST)
        |=> state_reg == DECIDE)
        else $error("fixed part length wrong");
    AST_TAIL_FIRST: assert property (@(posedge clk) disable iff (reset)
        (state_reg == TAIL && emit && cnt_reg == '0)
        |=> out_data.ch == sel_b_reg && out_data.resync)
        else $error("tail lead bit does not match variant");
    AST_LEVEL: assert property (@(posedge clk) disable iff (reset)
        emit |=> lvl_reg == ($past(lvl_reg) ^ out_data.ch)
        || ($past(final_reg) && state_reg == DECIDE))
        else $error("waveform level not toggled by one bit");
    AST_FINAL: assert property (@(posedge clk) disable iff (reset)
        (state_reg == DATA && emit && blk_end_reg && final_reg &&
        cnt_reg == last_reg) |=> state_reg == DECIDE)
        else $error("fixed part emitted after final block");

endmodule : resync_dc_balance_selector

// ### rtl/resync_pkg.sv
package resync_pkg;

    // ==========================================
    // widths and counts
    localparam int CHUNK_W = 64;
    localparam int NBITS_W = 7;
    localparam int SUM_W = 16;
    localparam int STEP_W = 6;
    localparam int N_STEPS = 39;
    localparam int FIFO_DEPTH = 32;
    localparam int TAIL_W = 4;
    localparam int FIX_W = 20;
    localparam logic [NBITS_W-1:0] TAIL_LAST = 7'h03;
    localparam logic [NBITS_W-1:0] FIX_LAST = 7'h13;

    // ==========================================
    // channel-bit patterns, first bit leftmost
    localparam logic [17:0] FIX_REST = 18'h10102;
    localparam logic [2:0] TAIL_A_HEAD = 3'h0;
    localparam logic [2:0] TAIL_B_HEAD = 3'h4;

    // ==========================================
    // carriers
    typedef struct packed {
        logic [CHUNK_W-1:0] data;
        logic [NBITS_W-1:0] nbits;
        logic last_of_block;
        logic last_of_field;
        logic x_bit;
        logic y_bit;
    } chunk_s;

    typedef struct packed {
        logic ch;
        logic resync;
    } chan_out_s;

    typedef struct packed {
        logic signed [SUM_W-1:0] sum;
        logic lvl;
    } dsv_s;

    // ==========================================
    // helpers
    function automatic dsv_s pwm_dsv(input logic [CHUNK_W-1:0] bits,
                                     input logic [NBITS_W-1:0] n,
                                     input logic lvl);
        dsv_s r;
        r.sum = '0;
        r.lvl = lvl;
        for (int i = 0; i < CHUNK_W; i++) begin
            if (NBITS_W'(i) < n) begin
                r.lvl = r.lvl ^ bits[CHUNK_W-1-i];
                r.sum = r.lvl ? r.sum + SUM_W'(1) : r.sum - SUM_W'(1);
            end
        end
        return r;
    endfunction : pwm_dsv

    function automatic logic [CHUNK_W-1:0] fix_vector(input logic x);
        return {1'b0, x, FIX_REST, {(CHUNK_W-FIX_W){1'b0}}};
    endfunction : fix_vector

    function automatic logic [CHUNK_W-1:0] tail_vector(input logic b,
                                                       input logic y);
        return {(b ? TAIL_B_HEAD : TAIL_A_HEAD), y,
                {(CHUNK_W-TAIL_W){1'b0}}};
    endfunction : tail_vector

    function automatic logic signed [SUM_W-1:0] abs_sum(
        input logic signed [SUM_W-1:0] v);
        return (v < 0) ? -v : v;
    endfunction : abs_sum

endpackage : resync_pkg

// ### verification/resync_dc_balance_selector_tb_top.sv
`timescale 1ns/1ps
module resync_dc_balance_selector_tb_top;
    // ==========================================
    // signals
    localparam int NS = 3;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic in_valid = 1'b0;
    resync_pkg::chunk_s in_chunk = '0;
    logic in_ready;
    logic out_valid;
    logic out_ready;
    logic tail_variant_b;
    resync_pkg::chan_out_s out_data;
    logic signed [resync_pkg::SUM_W-1:0] running_sum;
    logic slow = 1'b0;
    logic stall = 1'b0;
    int checks = 0;
    int bad_count = 0;
    int nw1 = 1;
    int acc = 0;
    bit sent = 0;
    logic [1:0] eq[$];
    logic [1:0] eb;
    logic exp_b;
    logic [15:0] exp_p;

    resync_dc_balance_selector #(.N_STEPS(NS),
        .DEPTH(resync_pkg::FIFO_DEPTH)) dut (
        .clk(clk), .reset(reset), .in_valid(in_valid),
        .in_chunk(in_chunk), .in_ready(in_ready),
        .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .tail_variant_b(tail_variant_b),
        .running_sum(running_sum));

    serial_sink_model sink (.clk(clk), .reset(reset), .slow(slow),
        .stall(stall), .out_ready(out_ready));

    initial begin
        forever #20 clk = ~clk;
    end

    // ==========================================
    // reporting
    task stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // ==========================================
    // field content, shared by stimulus and expectation
    function automatic logic [63:0] wdat(int s, int k, int w);
        return 64'h9248_4210_8844_2211 ^ {8{8'(s * 37 + k * 11 + w * 5)}};
    endfunction : wdat

    function automatic int wnb(int s, int k, int w);
        return 64 - (s * 13 + k * 7 + w * 3) % 40;
    endfunction : wnb

    function automatic int nwords(int k);
        return (k == 1) ? nw1 : ((k == 2) ? 2 : 1);
    endfunction : nwords

    function automatic int mag(int v);
        return (v < 0) ? -v : v;
    endfunction : mag

    function automatic logic [63:0] fixv(logic x);
        return {1'b0, x, 18'h10102, 44'h0};
    endfunction : fixv

    function automatic logic [63:0] tailv(logic b, logic y);
        return {(b ? 3'h4 : 3'h0), y, 60'h0};
    endfunction : tailv

    // ==========================================
    // expected stream and balance
    task automatic seg(input logic [63:0] d, input int n, input bit rs,
                       input bit push, inout logic l, inout int sm);
        for (int i = 0; i < n; i++) begin
            l = l ^ d[63-i];
            sm += l ? 1 : -1;
            if (push)
                eq.push_back({d[63-i], rs});
        end
    endtask : seg

    task automatic blk(input int s, input int k, input logic b,
                       input bit push, inout logic l, inout int sm);
        seg(tailv(b, (s * k) % 2 == 1), 4, 1, push, l, sm);
        for (int w = 0; w < nwords(k); w++)
            seg(wdat(s, k, w), wnb(s, k, w), 0, push, l, sm);
        if (k < NS)
            seg(fixv((s + k) % 2 == 1), 20, 1, push, l, sm);
    endtask : blk

    // each sector starts from level 0 and sum 0
    task automatic build(input int s);
        logic l;
        logic la;
        logic lb;
        int p;
        int da;
        int db;
        l = 1'b0;
        p = 0;
        eq.delete();
        seg(wdat(s, 0, 0), wnb(s, 0, 0), 0, 1, l, p);
        seg(fixv(s % 2 == 1), 20, 1, 1, l, p);
        for (int k = 1; k <= NS; k++) begin
            la = l;
            lb = l;
            da = 0;
            db = 0;
            blk(s, k, 1'b0, 0, la, da);
            blk(s, k, 1'b1, 0, lb, db);
            exp_b = mag(p + db) < mag(p + da);
            blk(s, k, exp_b, 1, l, p);
        end
        exp_p = 16'(p);
    endtask : build

    // ==========================================
    // encoder side driver, called at a falling edge
    task automatic send(input int s);
        int t;
        for (int k = 0; k <= NS; k++) begin
            for (int w = 0; w < nwords(k); w++) begin
                in_chunk.data = wdat(s, k, w);
                in_chunk.nbits = 7'(wnb(s, k, w));
                in_chunk.last_of_block = (w == nwords(k) - 1);
                in_chunk.last_of_field = (k == NS) && (w == nwords(k) - 1);
                in_chunk.x_bit = (s + k) % 2 == 1;
                in_chunk.y_bit = (s * k) % 2 == 1;
                in_valid = 1'b1;
                t = 0;
                while (in_ready !== 1'b1 && t < 5000) begin
                    @(negedge clk);
                    t++;
                end
                if (t >= 5000)
                    chk("send wait", 16'h0, 16'h1);
                @(negedge clk);
                acc++;
            end
        end
        in_valid = 1'b0;
    endtask : send

    task automatic fin(input string nm);
        int t;
        t = 0;
        while ((eq.size() > 0 || out_valid !== 1'b0) && t < 20000) begin
            @(negedge clk);
            t++;
        end
        if (t >= 20000)
            chk({nm, " drain wait"}, 16'h0, 16'h1);
        repeat (4) @(negedge clk);
        chk({nm, " queue"}, 16'h0, 16'(eq.size()));
        chk({nm, " running_sum"}, exp_p, running_sum);
        chk({nm, " tail_variant_b"}, 16'(exp_b), 16'(tail_variant_b));
    endtask : fin

    // every accepted bit must be the next one of the expected stream
    always @(posedge clk) begin
        if (!reset && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (eq.size() == 0)
                chk("extra bit", 16'h0, 16'h1);
            else begin
                eb = eq.pop_front();
                chk("ch bit", 16'(eb), 16'(out_data));
            end
        end
    end

    // ==========================================
    // scenarios
    task t_reset;
        chk("reset running_sum", 16'h0, running_sum);
        chk("reset tail", 16'h0, {15'h0, tail_variant_b});
        chk("reset out_valid", 16'h0, {15'h0, out_valid});
        chk("reset in_ready", 16'h0, {15'h0, in_ready});
    endtask : t_reset

    task t_basic;
        slow = 1'b1;
        build(1);
        send(1);
        fin("slow field");
    endtask : t_basic

    task t_second;
        slow = 1'b0;
        build(2);
        send(2);
        fin("second sector");
    endtask : t_second

    // a 32 word block against a stalled serialiser fills the fifo, then further input must be refused
    task t_fill;
        int t;
        nw1 = 32;
        stall = 1'b1;
        build(3);
        acc = 0;
        sent = 0;
        fork
            begin
                send(3);
                sent = 1;
            end
        join_none
        repeat (300) @(negedge clk);
        // head word sits in the shifter, so a full fifo ends at depth + 1
        chk("taken while full", 16'(resync_pkg::FIFO_DEPTH + 1), 16'(acc));
        chk("in_ready while full", 16'h0, {15'h0, in_ready});
        stall = 1'b0;
        t = 0;
        while (!sent && t < 20000) begin
            @(negedge clk);
            t++;
        end
        fin("filled fifo");
    endtask : t_fill

    initial begin
        repeat (18) @(negedge clk);
        t_reset();
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        t_basic();
        t_second();
        t_fill();
        stop_test();
    end

    // three fields take some 3500 cycles even when slowed
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule : resync_dc_balance_selector_tb_top

// ### verification/serial_sink_model.sv
`timescale 1ns/1ps
// ==========================================
// serialiser model: takes channel bits, may stall
module serial_sink_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pacing from the bench
    input wire logic slow,
    input wire logic stall,
    // accept strobe to the block
    output logic out_ready
);
    logic [1:0] cnt_reg;
    initial out_ready = 1'b0;
    initial cnt_reg = 2'h0;
    // slow mode takes one bit in four, a real serialiser may be slower
    always @(negedge clk) begin
        cnt_reg <= cnt_reg + 2'h1;
        out_ready <= !reset && !stall && (!slow || cnt_reg == 2'h0);
    end
endmodule : serial_sink_model
